//--- rtl/motion_regs_pkg.sv
package motion_regs_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_Z_OFFSET_TRIM_HIGH     = 8'h15;
  localparam logic [7:0] ADDR_OPERATING_MODE_CONTROL = 8'h16;
  localparam logic [7:0] ADDR_INTERRUPT_LATCH_CLEAR  = 8'h17;
  localparam logic [7:0] ADDR_DETECTION_CONTROL_ONE  = 8'h18;
  localparam logic [7:0] ADDR_DETECTION_CONTROL_TWO  = 8'h19;
  localparam logic [7:0] ADDR_LEVEL_THRESHOLD        = 8'h1a;
  localparam logic [7:0] ADDR_PULSE_THRESHOLD        = 8'h1b;
  localparam logic [7:0] ADDR_PULSE_DURATION         = 8'h1c;
  localparam logic [7:0] ADDR_PULSE_LATENCY          = 8'h1d;
  localparam logic [7:0] ADDR_SECOND_PULSE_WINDOW    = 8'h1e;

  // ****************************************************************
  // writable bit masks, reserved bits read zero
  // ****************************************************************
  localparam logic [7:0] MASK_Z_TRIM_HIGH = 8'h07;
  localparam logic [7:0] MASK_MODE_CTL    = 8'h7f;
  localparam logic [7:0] MASK_LATCH_CLR   = 8'h03;
  localparam logic [7:0] MASK_CTL_ONE     = 8'hff;
  localparam logic [7:0] MASK_CTL_TWO     = 8'h07;
  localparam logic [7:0] MASK_FULL        = 8'hff;
  localparam logic [7:0] RESET_BYTE       = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MODE_LSB         = 0;
  localparam int RANGE_LSB        = 2;
  localparam int SELF_TEST_BIT    = 4;
  localparam int THREE_WIRE_BIT   = 5;
  localparam int READY_OFF_BIT    = 6;
  localparam int CLR_ONE_BIT      = 0;
  localparam int CLR_TWO_BIT      = 1;
  localparam int PIN_SWAP_BIT     = 0;
  localparam int SRC_ASSIGN_LSB   = 1;
  localparam int AXIS_DIS_LSB     = 3;
  localparam int THR_OPTION_BIT   = 6;
  localparam int FILTER_BW_BIT    = 7;
  localparam int LEVEL_POL_BIT    = 0;
  localparam int PULSE_POL_BIT    = 1;
  localparam int DRIVE_BIT        = 2;
  localparam int THR_TOP_BIT      = 7;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_MEASURE = 2'h1;
  localparam logic [1:0] MODE_LEVEL   = 2'h2;
  localparam logic [1:0] MODE_PULSE   = 2'h3;
  localparam logic [1:0] RANGE_8G     = 2'h0;
  localparam logic [1:0] RANGE_2G     = 2'h1;
  localparam logic [1:0] RANGE_4G     = 2'h2;
  localparam logic [1:0] SRC_LVL_PLS  = 2'h0;
  localparam logic [1:0] SRC_PLS_LVL  = 2'h1;
  localparam logic [1:0] SRC_SGL_DBL  = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLOCK_KHZ        = 125000;
  localparam int PULSE_STEP_US    = 500;
  localparam int LATENCY_STEP_US  = 1000;
  localparam int PULSE_STEP_CYC   = PULSE_STEP_US * CLOCK_KHZ / 1000;
  localparam int LATENCY_STEP_CYC = LATENCY_STEP_US * CLOCK_KHZ / 1000;
  localparam int TICK_CNT_W       = 17;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [2:0] level_hit;
    logic [2:0] pulse_hit;
    logic       double_hit;
    logic       data_ready;
  } detect_in_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] range_select;
    logic       self_test_enable;
    logic       three_wire_select;
    logic       filter_bandwidth_select;
    logic       output_drive_select;
    logic [2:0] axis_disable;
    logic       threshold_option;
    logic       level_polarity;
    logic       pulse_polarity;
    logic [2:0] z_offset_trim;
    logic [7:0] level_threshold_value;
    logic [6:0] pulse_threshold_value;
    logic [7:0] pulse_duration_value;
    logic [7:0] latency_value;
    logic [7:0] second_window_value;
    logic       double_pulse_mode;
  } cfg_t;

  typedef struct packed {
    logic [2:0] level_flag;
    logic [2:0] pulse_flag;
    logic       irq_two;
    logic       irq_one;
  } detect_source_t;

endpackage

//--- rtl/motion_detect_control_regs.sv
`timescale 1ns/100ps

// Contract
// - z trim high holds bits 10..8 in low three bits, bit 10 polarity.
// - mode field: standby, measure, level detect, pulse detect.
// - range field: 00 8g, 01 2g, 10 4g.
// - self-test bit on D4 enables self-test when one.
// - D5 selects four-wire serial at zero, three-wire at one.
// - D6 zero puts data-ready onto interrupt-one pin; one keeps it off.
// - writing one to D0/D1 clears that latch and its source flags.
// - source field maps level/pulse, swapped, or single/single-or-double.
// - assign 10: irq two double-only when latency and window nonzero.
// - pin swap D0 zero routes pins straight, one crossed.
// - axis disable bits drop that axis from level and pulse detection.
// - threshold option picks absolute or signed level threshold only.
// - bandwidth bit picks 62.5 Hz at zero, 125 Hz at one.
// - level polarity zero: positive, OR axes; one: negative, AND axes.
// - pulse polarity zero: positive, OR axes; one: negative, AND axes.
// - level threshold unsigned 7-bit at option zero, signed 8-bit at one.
// - pulse threshold is unsigned 7 bits; host keeps top bit zero.
// - pulse duration counts 0.5 ms steps.
// - latency counts 1 ms steps.
// - second window counts 1 ms steps; minimum means single pulse.
// - axis level or single pulse hits set per-axis source flags.
module motion_detect_control_regs
  import motion_regs_pkg::*;
#(
  parameter int HALF_MS_CYCLES = PULSE_STEP_CYC,
  parameter int MS_CYCLES      = LATENCY_STEP_CYC
) (
  input  wire logic           clock,
  input  wire logic           srst,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  output logic [7:0]          reg_rdata,
  input  wire detect_in_t     detect_in,
  output cfg_t                cfg,
  output detect_source_t      detect_source,
  output logic                irq_one_pin,
  output logic                irq_two_pin,
  output logic                half_ms_tick,
  output logic                ms_tick
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]            ztrim;
    logic [7:0]            mode_ctl;
    logic [7:0]            latch_clr;
    logic [7:0]            ctl_one;
    logic [7:0]            ctl_two;
    logic [7:0]            lvl_thr;
    logic [7:0]            pls_thr;
    logic [7:0]            pls_dur;
    logic [7:0]            latency;
    logic [7:0]            window;
    logic [2:0]            level_flag;
    logic [2:0]            pulse_flag;
    logic                  irq_one;
    logic                  irq_two;
    logic                  pin_one;
    logic                  pin_two;
    logic [7:0]            rdata;
    cfg_t                  cfg;
    logic [TICK_CNT_W-1:0] half_cnt;
    logic [TICK_CNT_W-1:0] ms_cnt;
    logic                  half_tick;
    logic                  ms_tick;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [2:0] dis;
  logic [2:0] lvl_axis;
  logic [2:0] pls_axis;
  logic       level_evt;
  logic       single_evt;
  logic       pulse_evt;
  logic       dbl_mode;
  logic       irq_one_evt;
  logic       irq_two_evt;
  logic [1:0] src;
  logic       one_is_level;
  logic       two_is_level;
  logic       clr_one;
  logic       clr_two;
  logic       clr_level;
  logic       clr_pulse;
  logic       pol_l;
  logic       pol_p;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.latch_clr = RESET_BYTE;

    // register writes, reserved bits masked off
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_Z_OFFSET_TRIM_HIGH:
          st_nxt.ztrim = reg_wdata & MASK_Z_TRIM_HIGH;
        ADDR_OPERATING_MODE_CONTROL:
          st_nxt.mode_ctl = reg_wdata & MASK_MODE_CTL;
        ADDR_INTERRUPT_LATCH_CLEAR:
          st_nxt.latch_clr = reg_wdata & MASK_LATCH_CLR;
        ADDR_DETECTION_CONTROL_ONE:
          st_nxt.ctl_one = reg_wdata & MASK_CTL_ONE;
        ADDR_DETECTION_CONTROL_TWO:
          st_nxt.ctl_two = reg_wdata & MASK_CTL_TWO;
        ADDR_LEVEL_THRESHOLD:     st_nxt.lvl_thr = reg_wdata & MASK_FULL;
        ADDR_PULSE_THRESHOLD:     st_nxt.pls_thr = reg_wdata & MASK_FULL;
        ADDR_PULSE_DURATION:      st_nxt.pls_dur = reg_wdata & MASK_FULL;
        ADDR_PULSE_LATENCY:       st_nxt.latency = reg_wdata & MASK_FULL;
        ADDR_SECOND_PULSE_WINDOW: st_nxt.window  = reg_wdata & MASK_FULL;
        default: ;
      endcase
    end

    // ****************************************************************
    // detection combining
    // ****************************************************************
    dis = st_r.ctl_one[AXIS_DIS_LSB +: 3];
    pol_l = st_r.ctl_two[LEVEL_POL_BIT];
    pol_p = st_r.ctl_two[PULSE_POL_BIT];
    lvl_axis = detect_in.level_hit & ~dis;
    pls_axis = detect_in.pulse_hit & ~dis;
    // all-disabled must not pass the AND form
    if (pol_l) begin
      level_evt = &(detect_in.level_hit | dis) & ~&dis;
    end else begin
      level_evt = |lvl_axis;
    end
    if (pol_p) begin
      single_evt = &(detect_in.pulse_hit | dis) & ~&dis;
    end else begin
      single_evt = |pls_axis;
    end
    level_evt  = level_evt & (st_r.mode_ctl[MODE_LSB +: 2] == MODE_LEVEL);
    single_evt = single_evt
                 & (st_r.mode_ctl[MODE_LSB +: 2] == MODE_PULSE);
    dbl_mode = (st_r.window != RESET_BYTE)
               && (st_r.latency != RESET_BYTE);
    if (dbl_mode) begin
      pulse_evt = detect_in.double_hit
                  & (st_r.mode_ctl[MODE_LSB +: 2] == MODE_PULSE);
    end else begin
      pulse_evt = single_evt;
    end

    // ****************************************************************
    // source assignment
    // ****************************************************************
    src = st_r.ctl_one[SRC_ASSIGN_LSB +: 2];
    one_is_level = 1'b0;
    two_is_level = 1'b0;
    unique case (src)
      SRC_PLS_LVL: begin
        irq_one_evt  = pulse_evt;
        irq_two_evt  = level_evt;
        two_is_level = 1'b1;
      end
      SRC_SGL_DBL: begin
        irq_one_evt = single_evt;
        irq_two_evt = pulse_evt;
      end
      default: begin
        // code 11 is undefined; it behaves as 00
        irq_one_evt  = level_evt;
        irq_two_evt  = pulse_evt;
        one_is_level = 1'b1;
      end
    endcase

    // ****************************************************************
    // latches and flags, set wins over clear
    // ****************************************************************
    clr_one = st_r.latch_clr[CLR_ONE_BIT];
    clr_two = st_r.latch_clr[CLR_TWO_BIT];
    clr_level = (clr_one & one_is_level) | (clr_two & two_is_level);
    clr_pulse = (clr_one & ~one_is_level) | (clr_two & ~two_is_level);
    st_nxt.irq_one = (st_r.irq_one & ~clr_one) | irq_one_evt;
    st_nxt.irq_two = (st_r.irq_two & ~clr_two) | irq_two_evt;
    st_nxt.level_flag = (st_r.level_flag & ~{3{clr_level}})
      | (lvl_axis & {3{st_r.mode_ctl[MODE_LSB +: 2] == MODE_LEVEL}});
    st_nxt.pulse_flag = (st_r.pulse_flag & ~{3{clr_pulse}})
      | (pls_axis & {3{st_r.mode_ctl[MODE_LSB +: 2] == MODE_PULSE}});

    // ****************************************************************
    // pins
    // ****************************************************************
    if (st_r.ctl_one[PIN_SWAP_BIT]) begin
      st_nxt.pin_one = st_nxt.irq_two;
      st_nxt.pin_two = st_nxt.irq_one;
    end else begin
      st_nxt.pin_one = st_nxt.irq_one;
      st_nxt.pin_two = st_nxt.irq_two;
    end
    st_nxt.pin_one = st_nxt.pin_one
      | (detect_in.data_ready & ~st_r.mode_ctl[READY_OFF_BIT]);

    // ****************************************************************
    // timer step ticks
    // ****************************************************************
    st_nxt.half_tick = 1'b0;
    st_nxt.ms_tick   = 1'b0;
    if (st_r.half_cnt == TICK_CNT_W'(HALF_MS_CYCLES - 1)) begin
      st_nxt.half_cnt  = '0;
      st_nxt.half_tick = 1'b1;
    end else begin
      st_nxt.half_cnt = st_r.half_cnt + TICK_CNT_W'(1);
    end
    if (st_r.ms_cnt == TICK_CNT_W'(MS_CYCLES - 1)) begin
      st_nxt.ms_cnt  = '0;
      st_nxt.ms_tick = 1'b1;
    end else begin
      st_nxt.ms_cnt = st_r.ms_cnt + TICK_CNT_W'(1);
    end

    // ****************************************************************
    // decoded configuration
    // ****************************************************************
    st_nxt.cfg.mode              = st_nxt.mode_ctl[MODE_LSB +: 2];
    st_nxt.cfg.range_select      = st_nxt.mode_ctl[RANGE_LSB +: 2];
    st_nxt.cfg.self_test_enable  = st_nxt.mode_ctl[SELF_TEST_BIT];
    st_nxt.cfg.three_wire_select = st_nxt.mode_ctl[THREE_WIRE_BIT];
    st_nxt.cfg.filter_bandwidth_select =
      st_nxt.ctl_one[FILTER_BW_BIT];
    st_nxt.cfg.output_drive_select = st_nxt.ctl_two[DRIVE_BIT];
    st_nxt.cfg.axis_disable     = st_nxt.ctl_one[AXIS_DIS_LSB +: 3];
    st_nxt.cfg.threshold_option = st_nxt.ctl_one[THR_OPTION_BIT];
    st_nxt.cfg.level_polarity   = st_nxt.ctl_two[LEVEL_POL_BIT];
    st_nxt.cfg.pulse_polarity   = st_nxt.ctl_two[PULSE_POL_BIT];
    st_nxt.cfg.z_offset_trim    = st_nxt.ztrim[2:0];
    // absolute form ignores a stray top bit
    if (st_nxt.ctl_one[THR_OPTION_BIT]) begin
      st_nxt.cfg.level_threshold_value = st_nxt.lvl_thr;
    end else begin
      st_nxt.cfg.level_threshold_value = {1'b0, st_nxt.lvl_thr[6:0]};
    end
    st_nxt.cfg.pulse_threshold_value = st_nxt.pls_thr[6:0];
    st_nxt.cfg.pulse_duration_value  = st_nxt.pls_dur;
    st_nxt.cfg.latency_value         = st_nxt.latency;
    st_nxt.cfg.second_window_value   = st_nxt.window;
    st_nxt.cfg.double_pulse_mode =
      (st_nxt.window != RESET_BYTE) && (st_nxt.latency != RESET_BYTE);

    // ****************************************************************
    // readback, one cycle after the address
    // ****************************************************************
    unique case (reg_addr)
      ADDR_Z_OFFSET_TRIM_HIGH:     st_nxt.rdata = st_r.ztrim;
      ADDR_OPERATING_MODE_CONTROL: st_nxt.rdata = st_r.mode_ctl;
      ADDR_INTERRUPT_LATCH_CLEAR:  st_nxt.rdata = st_r.latch_clr;
      ADDR_DETECTION_CONTROL_ONE:  st_nxt.rdata = st_r.ctl_one;
      ADDR_DETECTION_CONTROL_TWO:  st_nxt.rdata = st_r.ctl_two;
      ADDR_LEVEL_THRESHOLD:        st_nxt.rdata = st_r.lvl_thr;
      ADDR_PULSE_THRESHOLD:        st_nxt.rdata = st_r.pls_thr;
      ADDR_PULSE_DURATION:         st_nxt.rdata = st_r.pls_dur;
      ADDR_PULSE_LATENCY:          st_nxt.rdata = st_r.latency;
      ADDR_SECOND_PULSE_WINDOW:    st_nxt.rdata = st_r.window;
      default:                     st_nxt.rdata = RESET_BYTE;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata                = st_r.rdata;
  assign cfg                      = st_r.cfg;
  assign detect_source.level_flag = st_r.level_flag;
  assign detect_source.pulse_flag = st_r.pulse_flag;
  assign detect_source.irq_two    = st_r.irq_two;
  assign detect_source.irq_one    = st_r.irq_one;
  assign irq_one_pin              = st_r.pin_one;
  assign irq_two_pin              = st_r.pin_two;
  assign half_ms_tick             = st_r.half_tick;
  assign ms_tick                  = st_r.ms_tick;

endmodule

//--- verif/host_model.sv
`timescale 1ns/100ps
// ********
// host side of the register port
// ********
module host_model
  import motion_regs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr
);
  logic thr_opt_r = 1'b0;
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
  end
  // two cycles a write: the strobe never moves twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_PULSE_THRESHOLD) d[7] = 1'b0;
    if (a == ADDR_LEVEL_THRESHOLD && !thr_opt_r) d[7] = 1'b0;
    if (a == ADDR_DETECTION_CONTROL_ONE) thr_opt_r = d[THR_OPTION_BIT];
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    reg_addr <= a;
    @(posedge clock);
    @(negedge clock);
    q = reg_rdata;
    @(posedge clock);
  endtask
endmodule

//--- verif/motion_regs_checker_assertions.sv
`timescale 1ns/100ps
module motion_regs_checker
  import motion_regs_pkg::*;
#(
  parameter int HALF_MS_CYCLES = 4,
  parameter int MS_CYCLES      = 8
) (
  input wire logic           clock,
  input wire logic           srst,
  input wire logic [7:0]     reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           reg_wr,
  input wire logic [7:0]     reg_rdata,
  input wire detect_in_t     detect_in,
  input wire cfg_t           cfg,
  input wire detect_source_t detect_source,
  input wire logic           irq_one_pin,
  input wire logic           irq_two_pin,
  input wire logic           half_ms_tick,
  input wire logic           ms_tick
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ********
  // mirrors of control bits that cfg does not carry, and half ms tick spacing trackers
  // ********
  logic [7:0] ctl_r;
  logic       ready_off_r;
  int         gap_r;
  logic       seen_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      ctl_r      <= 8'h00;
      ready_off_r <= 1'b0;
      gap_r      <= 0;
      seen_r     <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_DETECTION_CONTROL_ONE)
        ctl_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_OPERATING_MODE_CONTROL)
        ready_off_r <= reg_wdata[READY_OFF_BIT];
      gap_r  <= half_ms_tick ? 0 : gap_r + 1;
      seen_r <= seen_r | half_ms_tick;
    end
  end
  sequence latch_wr;
    reg_wr && reg_addr == ADDR_INTERRUPT_LATCH_CLEAR;
  endsequence
  sequence latch_idle;
    !reg_wr && reg_addr == ADDR_INTERRUPT_LATCH_CLEAR;
  endsequence
  sequence quiet;
    detect_in.level_hit == 3'h0 && detect_in.pulse_hit == 3'h0
      && !detect_in.double_hit;
  endsequence
  sequence lvl_ev;
    cfg.mode == MODE_LEVEL && !cfg.level_polarity && !ctl_r[2]
      && (detect_in.level_hit & ~cfg.axis_disable) != 3'h0;
  endsequence
  AST_MODE_WR: assert property (
    reg_wr && reg_addr == ADDR_OPERATING_MODE_CONTROL |=>
      cfg.mode == $past(reg_wdata[1:0])
      && cfg.range_select == $past(reg_wdata[3:2]))
    else $error("mode or range not taken from write");
  AST_LEVEL_FLAG: assert property (
    cfg.mode == MODE_LEVEL && detect_in.level_hit[1] && !cfg.level_polarity
      && !cfg.axis_disable[1] |=> detect_source.level_flag[1])
    else $error("level flag y not set");
  AST_AXIS_OFF: assert property (
    cfg.axis_disable[0] |=> !$rose(detect_source.level_flag[0])
      && !$rose(detect_source.pulse_flag[0]))
    else $error("disabled axis raised a flag");
  AST_DATA_READY_FLAG_PIN: assert property (
    detect_in.data_ready && !ready_off_r |=> irq_one_pin)
    else $error("data ready missing on pin one");
  AST_CLEAR_ONE: assert property (
    latch_wr ##0 reg_wdata[0] ##1 quiet |=> !detect_source.irq_one)
    else $error("latch one not cleared");
  AST_CLR_SELF: assert property (
    latch_wr ##1 latch_idle [*2] |=> reg_rdata == 8'h00)
    else $error("clear bits did not return to zero");
  AST_PIN_ROUTE: assert property (
    ctl_r[0] == $past(ctl_r[0]) |-> irq_two_pin ==
      (ctl_r[0] ? detect_source.irq_one : detect_source.irq_two))
    else $error("pin two routing wrong");
  AST_SRC_STRAIGHT: assert property (
    lvl_ev ##0 !ctl_r[1] |=> detect_source.irq_one)
    else $error("level event missed latch one");
  AST_SRC_SWAPPED: assert property (
    lvl_ev ##0 ctl_r[1] |=> detect_source.irq_two)
    else $error("level event missed latch two");
  AST_HALF_TICK: assert property (
    half_ms_tick && seen_r |-> gap_r == HALF_MS_CYCLES - 1)
    else $error("half ms tick spacing wrong");
endmodule

bind motion_detect_control_regs motion_regs_checker #(
  .HALF_MS_CYCLES(HALF_MS_CYCLES),
  .MS_CYCLES     (MS_CYCLES)
) motion_regs_checker_inst (
  .clock        (clock),
  .srst         (srst),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_wr       (reg_wr),
  .reg_rdata    (reg_rdata),
  .detect_in    (detect_in),
  .cfg          (cfg),
  .detect_source(detect_source),
  .irq_one_pin  (irq_one_pin),
  .irq_two_pin  (irq_two_pin),
  .half_ms_tick (half_ms_tick),
  .ms_tick      (ms_tick)
);

//--- verif/tb.sv
`timescale 1ns/100ps
module tb
  import motion_regs_pkg::*;
();
  logic [7:0]     reg_addr, reg_wdata, reg_rdata, q;
  logic           clock = 1'b0;
  logic           srst  = 1'b1;
  logic           reg_wr, pin1, pin2, irq1_pin, irq2_pin, htick, mtick;
  detect_in_t     det   = '0;
  cfg_t           cfg;
  detect_source_t src, sv;
  int             err_count = 0;
  int             cmp_count = 0;
  int             mreg [10] = '{default: 0};
  int             msk [10]  = '{7, 127, 0, 255, 7, 255, 255, 255, 255, 255};
  int             qh [$];
  int             qm [$];
  always #4 clock = ~clock;
  host_model host_model_inst (.clock(clock), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));
  // short tick periods keep the run brief
  motion_detect_control_regs #(.HALF_MS_CYCLES(4), .MS_CYCLES(8))
  motion_detect_control_regs_inst (.clock(clock), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .detect_in(det), .cfg(cfg),
    .detect_source(src), .irq_one_pin(irq1_pin), .irq_two_pin(irq2_pin),
    .half_ms_tick(htick), .ms_tick(mtick));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_cfg();
    check(cfg.z_offset_trim, mreg[0]);
    check(cfg.mode, mreg[1] & 3);
    check(cfg.range_select, mreg[1] >> 2 & 3);
    check(cfg.self_test_enable, mreg[1] >> 4 & 1);
    check(cfg.three_wire_select, mreg[1] >> 5 & 1);
    check(cfg.axis_disable, mreg[3] >> 3 & 7);
    check(cfg.threshold_option, mreg[3] >> 6 & 1);
    check(cfg.filter_bandwidth_select, mreg[3] >> 7);
    check({cfg.output_drive_select, cfg.pulse_polarity,
           cfg.level_polarity}, mreg[4] & 7);
    check(cfg.level_threshold_value,
          mreg[3] >> 6 & 1 ? mreg[5] : mreg[5] & 127);
    check(cfg.pulse_threshold_value, mreg[6]);
    check(cfg.pulse_duration_value, mreg[7]);
    check(cfg.latency_value, mreg[8]);
    check(cfg.second_window_value, mreg[9]);
    check(cfg.double_pulse_mode, mreg[8] != 0 && mreg[9] != 0);
  endtask
  task automatic wr_chk(input int a, input logic [7:0] d);
    mreg[a - 'h15] = d & msk[a - 'h15];
    host_model_inst.wr(a[7:0], d);
    host_model_inst.rd(a[7:0], q);
    check(q, mreg[a - 'h15]);
    chk_cfg();
  endtask
  task automatic ev(input logic [2:0] l, input logic [2:0] p,
                    input logic dbl, input logic dr);
    det <= '{level_hit: l, pulse_hit: p, double_hit: dbl, data_ready: dr};
    @(posedge clock);
    det <= '0;
    @(negedge clock);
    pin1 = irq1_pin;
    pin2 = irq2_pin;
    sv   = src;
    @(posedge clock);
  endtask
  task automatic src_is(input logic [7:0] e);
    @(negedge clock);
    check(src, e);
    @(posedge clock);
  endtask
  task automatic clr(input logic [7:0] b);
    host_model_inst.wr(ADDR_INTERRUPT_LATCH_CLEAR, b);
    host_model_inst.rd(ADDR_INTERRUPT_LATCH_CLEAR, q);
    check(q, 8'h00);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("Error at %0t: run did not finish", $time);
    finish_test();
  end
  initial begin
    void'($urandom(32'hf59d_f426));
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      host_model_inst.rd(8'h15 + i[7:0], q);
      check(q, 8'h00);
    end
    src_is(8'h00);
    host_model_inst.wr(8'h20, 8'hff);
    host_model_inst.rd(8'h20, q);
    check(q, 8'h00);
    for (int k = 0; k < 20; k++) begin
      int a, d;
      a = 'h15 + k % 10;
      d = $urandom & (a inside {'h1a, 'h1b} ? 'h7f : 'hff);
      if (a != 'h17) wr_chk(a, d);
    end
    for (int i = 0; i < 4; i++) wr_chk('h16, i * 5 | 'h40);
    wr_chk('h18, 8'h40);
    wr_chk('h1a, 8'h80);
    for (int c = 0; c < 40; c++) begin
      @(negedge clock);
      if (htick === 1'b1) qh.push_back(c);
      if (mtick === 1'b1) qm.push_back(c);
    end
    @(posedge clock);
    if (qh.size() < 2 || qm.size() < 2) begin
      err_count++;
      $display("Error at %0t: ticks missing", $time);
    end else begin
      check(qh[1] - qh[0], 4);
      check(qm[1] - qm[0], 8);
    end
    // level detection, straight then swapped routing
    wr_chk('h18, 8'h00);
    wr_chk('h19, 8'h00);
    wr_chk('h1d, 8'h00);
    wr_chk('h1e, 8'h00);
    wr_chk('h16, 8'h42);
    ev(3'h1, 3'h0, 1'b0, 1'b0);
    src_is(8'h21);
    check({pin1, pin2}, 8'h02);
    clr(8'h02);
    src_is(8'h21);
    clr(8'h01);
    src_is(8'h00);
    wr_chk('h18, 8'h03);
    ev(3'h2, 3'h0, 1'b0, 1'b0);
    src_is(8'h42);
    check({pin1, pin2}, 8'h02);
    clr(8'h02);
    src_is(8'h00);
    wr_chk('h18, 8'h08);
    ev(3'h1, 3'h0, 1'b0, 1'b0);
    src_is(8'h00);
    // and-combining: z is off, so x and y must both hit
    wr_chk('h18, 8'h20);
    wr_chk('h19, 8'h01);
    ev(3'h1, 3'h0, 1'b0, 1'b0);
    check(sv.irq_one, 8'h00);
    ev(3'h3, 3'h0, 1'b0, 1'b0);
    check(sv.irq_one, 8'h01);
    clr(8'h01);
    wr_chk('h19, 8'h00);
    wr_chk('h16, 8'h02);
    ev(3'h0, 3'h0, 1'b0, 1'b1);
    check({pin1, sv.irq_one}, 8'h02);
    wr_chk('h16, 8'h42);
    ev(3'h0, 3'h0, 1'b0, 1'b1);
    check(pin1, 8'h00);
    // pulse detection: source assignments 00 and 10, then double mode
    wr_chk('h16, 8'h43);
    wr_chk('h18, 8'h00);
    ev(3'h0, 3'h2, 1'b0, 1'b0);
    src_is(8'h0a);
    clr(8'h02);
    src_is(8'h00);
    wr_chk('h18, 8'h04);
    ev(3'h0, 3'h4, 1'b0, 1'b0);
    src_is(8'h13);
    clr(8'h03);
    wr_chk('h1d, 8'h01);
    wr_chk('h1e, 8'h01);
    ev(3'h0, 3'h1, 1'b0, 1'b0);
    src_is(8'h05);
    ev(3'h0, 3'h0, 1'b1, 1'b0);
    src_is(8'h07);
    finish_test();
  end
endmodule
